// file: rtl/apsf_pkg.sv
// package: field layout and types for the picture-state field decoder
package apsf_pkg;

  // ==========================================================================
  // dword 4 field positions
  localparam int SYNC_OVR_BIT   = 17;
  localparam int SYNC_ROOT_BIT  = 16;
  localparam int MV16_EN_BIT    = 12;
  localparam int CHROMA_HI      = 11;
  localparam int CHROMA_LO      = 10;
  localparam int DBK_WR_BIT     = 8;
  localparam int ENTROPY_BIT    = 7;
  localparam int NONREF_BIT     = 6;
  localparam int CIP_BIT        = 5;
  localparam int DIRECT8_BIT    = 4;
  localparam int XFORM8_BIT     = 3;
  localparam int FRAME_ONLY_BIT = 2;
  localparam int MBAFF_BIT      = 1;
  localparam int FIELD_PIC_BIT  = 0;

  // ==========================================================================
  // command dword indices and register offsets
  localparam logic [3:0] DW_FLAGS  = 4'h4;
  localparam logic [3:0] DW_HEADER = 4'h5;
  localparam logic [3:0] REG_FLAGS  = 4'h0;
  localparam logic [3:0] REG_HEADER = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;

  // ==========================================================================
  // encodings and reset values
  localparam logic [1:0] CHROMA_MONO = 2'h0;
  localparam logic [1:0] CHROMA_420  = 2'h1;
  localparam logic [1:0] MV_SIZE_16  = 2'h1;
  localparam logic [1:0] MV_SIZE_32  = 2'h2;
  localparam logic [1:0] MB_INTRA    = 2'h0;
  localparam logic [1:0] MB_PCM      = 2'h3;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    APSF_IDLE = 2'b00,
    APSF_HAVE_FLAGS = 2'b01,
    APSF_READY = 2'b11
  } apsf_state_t;

  // decoded picture state
  typedef struct packed {
    logic       sync_ovr;
    logic       sync_root;
    logic       mv16_en;
    logic [1:0] chroma;
    logic       mono;
    logic       dbk_wr;
    logic       entropy_cabac;
    logic       non_ref;
    logic       cip;
    logic       direct8;
    logic       xform8;
    logic       frame_only;
    logic       mbaff;
    logic       field_pic;
  } apsf_state_fields_t;

  // per-macroblock request from the bitstream decoder
  typedef struct packed {
    logic [1:0] mb_kind;
    logic       nbr_avail;
    logic [1:0] mv_size;
    logic       dbk_slice_en;
  } apsf_mb_in_t;

  // per-macroblock object output
  typedef struct packed {
    logic [31:0] header;
    logic        sync;
    logic [1:0]  mv_size;
    logic        dbk_write;
    logic        dbk_nofilter;
  } apsf_mb_out_t;

endpackage : apsf_pkg

// file: rtl/apsf_picture_state.sv
// picture-state field decoder for the AVC bitstream decoder
`timescale 1ns/100ps
`default_nettype none
module apsf_picture_state
  import apsf_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         cmd_valid,
  input  wire logic [3:0]   cmd_dword,
  input  wire logic [31:0]  cmd_data,
  input  wire logic         mb_valid,
  input  wire apsf_mb_in_t  mb_in,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output var  logic [31:0]  reg_rdata,
  output var  logic         mb_out_valid,
  output var  apsf_mb_out_t mb_out,
  output var  apsf_state_fields_t pic_state,
  output var  logic         state_valid,
  output var  logic         chroma_unsupported
);

  // ==========================================================================
  // command capture
  apsf_state_t        state;
  apsf_state_t        next_state;
  apsf_state_fields_t staged;
  logic [31:0]        hdr_staged;
  logic [31:0]        hdr_word;
  logic [31:0]        flags_raw;

  wire logic take_flags  = cmd_valid && (cmd_dword == DW_FLAGS);
  wire logic take_header = cmd_valid && (cmd_dword == DW_HEADER);
  wire logic sw_flags    = reg_wr && (reg_addr == REG_FLAGS);
  wire logic sw_header   = reg_wr && (reg_addr == REG_HEADER);
  wire logic [31:0] flags_in = sw_flags ? reg_wdata : cmd_data;
  wire logic load_flags  = take_flags || sw_flags;
  wire logic load_header = take_header || sw_header;

  // mbaff honoured only when the picture is a frame and frame_only is clear
  wire logic fld_in   = flags_in[FIELD_PIC_BIT];
  wire logic fonly_in = flags_in[FRAME_ONLY_BIT];
  wire logic mbaff_in = flags_in[MBAFF_BIT] && !fld_in && !fonly_in;
  wire logic [1:0] chroma_in = flags_in[CHROMA_HI:CHROMA_LO];

  wire apsf_state_fields_t decoded = '{
    sync_ovr:      flags_in[SYNC_OVR_BIT],
    sync_root:     flags_in[SYNC_ROOT_BIT],
    mv16_en:       flags_in[MV16_EN_BIT],
    chroma:        chroma_in,
    mono:          (chroma_in == CHROMA_MONO),
    dbk_wr:        flags_in[DBK_WR_BIT],
    entropy_cabac: flags_in[ENTROPY_BIT],
    non_ref:       flags_in[NONREF_BIT],
    cip:           flags_in[CIP_BIT],
    direct8:       flags_in[DIRECT8_BIT],
    xform8:        flags_in[XFORM8_BIT],
    frame_only:    fonly_in,
    mbaff:         mbaff_in,
    field_pic:     fld_in && !fonly_in
  };

  always_comb begin
    next_state = state;
    case (state)
      APSF_IDLE:       if (load_flags) next_state = APSF_HAVE_FLAGS;
      APSF_HAVE_FLAGS: if (load_header) next_state = APSF_READY;
      APSF_READY:      if (load_flags) next_state = APSF_HAVE_FLAGS;
      default:         next_state = APSF_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= APSF_IDLE;
      staged     <= '0;
      hdr_staged <= RST_WORD;
      flags_raw  <= RST_WORD;
    end else begin
      state <= next_state;
      if (load_flags) begin
        staged    <= decoded;
        flags_raw <= flags_in;
      end
      if (load_header) hdr_staged <= sw_header ? reg_wdata : cmd_data;
    end
  end

  // whole picture state committed together, held until the next flags and header pair
  wire logic commit = (state == APSF_HAVE_FLAGS) && load_header;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pic_state          <= '0;
      hdr_word           <= RST_WORD;
      state_valid        <= 1'b0;
      chroma_unsupported <= 1'b0;
    end else if (commit) begin
      pic_state          <= staged;
      hdr_word           <= sw_header ? reg_wdata : cmd_data;
      state_valid        <= 1'b1;
      chroma_unsupported <= staged.chroma[1];
    end
  end

  // raw flags of the committed picture, kept only for the checks
  logic [31:0] committed_raw;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) committed_raw <= RST_WORD;
    else if (commit) committed_raw <= flags_raw;
  end

  // ==========================================================================
  // per-macroblock object generation
  wire logic intra_mb  = (mb_in.mb_kind == MB_INTRA);
  wire logic hw_sync   = intra_mb && mb_in.nbr_avail;
  wire logic next_sync = pic_state.sync_ovr ? hw_sync
                                            : pic_state.sync_root;
  wire logic [1:0] next_mv =
    (!pic_state.mv16_en && mb_in.mv_size == MV_SIZE_16) ? MV_SIZE_32
                                                        : mb_in.mv_size;
  wire logic next_dbk_wr = pic_state.dbk_wr;
  wire logic next_nofilt = pic_state.dbk_wr && !mb_in.dbk_slice_en;
  wire logic mb_go       = mb_valid && state_valid;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mb_out_valid <= 1'b0;
      mb_out       <= '0;
    end else begin
      mb_out_valid <= mb_go;
      if (mb_go) begin
        mb_out.header       <= hdr_word;
        mb_out.sync         <= next_sync;
        mb_out.mv_size      <= next_mv;
        mb_out.dbk_write    <= next_dbk_wr;
        mb_out.dbk_nofilter <= next_nofilt;
      end
    end
  end

  // ==========================================================================
  // register read port, data one cycle after the strobe
  // header reads show the last word written, even one not yet committed
  wire logic [31:0] status_word = {29'h0000_0000, chroma_unsupported,
                                   state == APSF_HAVE_FLAGS, state_valid};
  wire logic [31:0] rd_mux =
    (reg_addr == REG_FLAGS)  ? flags_raw :
    (reg_addr == REG_HEADER) ? hdr_staged :
    (reg_addr == REG_STATUS) ? status_word : RST_WORD;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= RST_WORD;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // ==========================================================================
  // elaboration checks on the field map
  if (SYNC_OVR_BIT > 31 || SYNC_ROOT_BIT > 31) begin : g_bad_sync
    $error("sync bits fall outside the flags dword");
  end
  if (CHROMA_HI != CHROMA_LO + 1) begin : g_bad_chroma
    $error("chroma field is not two adjacent bits");
  end
  if ($bits(apsf_mb_out_t) != 37) begin : g_bad_object
    $error("macroblock object layout changed");
  end

  // ==========================================================================
  // checks
  a_sync_copy: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && !pic_state.sync_ovr |=> mb_out_valid && mb_out.sync == $past(pic_state.sync_root))
    else $error("sync bit not forwarded");
  a_sync_hw: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && pic_state.sync_ovr && mb_in.mb_kind != MB_INTRA |=> !mb_out.sync)
    else $error("non-intra macroblock marked synchronised");
  a_sync_ovr_on: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && pic_state.sync_ovr && intra_mb && mb_in.nbr_avail |=> mb_out.sync)
    else $error("overwrite ignored intra sync");
  a_mv_map: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && !pic_state.mv16_en && mb_in.mv_size == MV_SIZE_16 |=> mb_out.mv_size == MV_SIZE_32)
    else $error("sixteen-vector not remapped");
  a_mono_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid |-> pic_state.mono == (pic_state.chroma == CHROMA_MONO))
    else $error("monochrome indication wrong");
  a_dbk_off: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && !pic_state.dbk_wr |=> !mb_out.dbk_write && !mb_out.dbk_nofilter)
    else $error("deblock data written while disabled");
  a_dbk_fill: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && pic_state.dbk_wr && !mb_in.dbk_slice_en |=> mb_out.dbk_write && mb_out.dbk_nofilter)
    else $error("no-filter fill missing");
  a_mbaff_frame: assert property (@(posedge mclk) disable iff (!rst_n)
    pic_state.field_pic |-> !pic_state.mbaff)
    else $error("mbaff active on field picture");
  a_header_use: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go |=> mb_out.header == $past(hdr_word))
    else $error("header dword mismatch");
  a_state_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !commit |=> $stable(pic_state))
    else $error("picture state changed without command");

  a_root_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.sync_root == committed_raw[SYNC_ROOT_BIT])
    else $error("root sync field not latched");

  a_ovr_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.sync_ovr == committed_raw[SYNC_OVR_BIT])
    else $error("sync overwrite field not latched");

  a_mv16_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.mv16_en == committed_raw[MV16_EN_BIT])
    else $error("sixteen-vector enable not latched");

  a_mv_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && (pic_state.mv16_en || mb_in.mv_size != MV_SIZE_16)
    |=> mb_out.mv_size == $past(mb_in.mv_size))
    else $error("vector size changed without cause");

  a_chroma_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.chroma == committed_raw[CHROMA_HI:CHROMA_LO])
    else $error("chroma format not latched");

  a_unsup_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> chroma_unsupported == committed_raw[CHROMA_HI])
    else $error("unsupported chroma flag wrong");

  a_mono_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.mono == (committed_raw[CHROMA_HI:CHROMA_LO] == CHROMA_MONO))
    else $error("monochrome indication not derived");

  a_dbk_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.dbk_wr == committed_raw[DBK_WR_BIT])
    else $error("deblock write enable not latched");

  a_dbk_pass: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && pic_state.dbk_wr && mb_in.dbk_slice_en
    |=> mb_out.dbk_write && !mb_out.dbk_nofilter)
    else $error("filtered slice marked no-filter");

  a_entropy_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.entropy_cabac == committed_raw[ENTROPY_BIT])
    else $error("entropy mode not latched");

  a_nonref_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.non_ref == committed_raw[NONREF_BIT])
    else $error("non-reference flag not latched");

  a_cip_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.cip == committed_raw[CIP_BIT])
    else $error("constrained intra flag not latched");

  a_direct_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.direct8 == committed_raw[DIRECT8_BIT])
    else $error("direct inference flag not latched");

  a_xform_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.xform8 == committed_raw[XFORM8_BIT])
    else $error("transform size flag not latched");

  a_fonly_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.frame_only == committed_raw[FRAME_ONLY_BIT])
    else $error("frame-only flag not latched");

  a_fonly_block: assert property (@(posedge mclk) disable iff (!rst_n)
    pic_state.frame_only
    |-> !pic_state.mbaff && !pic_state.field_pic)
    else $error("field or mbaff allowed on frame-only picture");

  a_mbaff_field: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.mbaff == (committed_raw[MBAFF_BIT] && !committed_raw[FIELD_PIC_BIT]
                            && !committed_raw[FRAME_ONLY_BIT]))
    else $error("mbaff not gated by frame picture");

  a_field_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    state_valid
    |-> pic_state.field_pic == (committed_raw[FIELD_PIC_BIT] && !committed_raw[FRAME_ONLY_BIT]))
    else $error("field picture flag wrong");

  a_ovr_nbr: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go && pic_state.sync_ovr && !mb_in.nbr_avail
    |=> !mb_out.sync)
    else $error("macroblock without neighbour marked synchronised");

  a_mb_answer: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_go
    |=> mb_out_valid)
    else $error("accepted macroblock produced no object");

  a_mb_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
    mb_valid && !state_valid
    |=> !mb_out_valid)
    else $error("object produced before picture state");

  a_commit_valid: assert property (@(posedge mclk) disable iff (!rst_n)
    commit
    |=> state_valid)
    else $error("state not valid after command");

  a_header_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    !commit
    |=> $stable(hdr_word))
    else $error("object header changed without command");

  a_status_read: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == REG_STATUS
    |=> reg_rdata[0] == $past(state_valid))
    else $error("status read shows wrong valid bit");

endmodule : apsf_picture_state
`default_nettype wire

// file: verification/apsf_cmd_model.sv
// partner model: command streamer issuing picture-state dwords
`timescale 1ns/100ps
`default_nettype none
module apsf_cmd_model
  import apsf_pkg::*;
(
  input  wire logic        mclk,
  output var  logic        cmd_valid,
  output var  logic [3:0]  cmd_dword,
  output var  logic [31:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_dword = 4'h0;
    cmd_data  = 32'h0000_0000;
  end
  // ==========================================================================
  // command issue
  task automatic send(input logic [31:0] flags, input logic [31:0] hdr, input logic fix,
                      input logic junk, input logic hdr_only, output logic [31:0] sent);
    sent = flags;
    if (fix) sent[MBAFF_BIT] = sent[MBAFF_BIT] & ~sent[FIELD_PIC_BIT];
    if (!hdr_only) begin
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_dword <= DW_FLAGS;
      cmd_data  <= sent;
    end
    // foreign dword between the pair, must be ignored
    if (junk) begin
      @(posedge mclk);
      cmd_dword <= 4'h3;
      cmd_data  <= ~sent;
    end
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_dword <= DW_HEADER;
    cmd_data  <= hdr;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    // released line shows inverse, never the stale dword
    cmd_data  <= ~hdr;
  endtask : send
endmodule : apsf_cmd_model
`default_nettype wire

// file: verification/testbench.sv
// testbench: picture-state decoder against a behavioural model
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module testbench;
  import apsf_pkg::*;
  logic mclk, rst_n, cmd_valid, mb_valid, reg_wr, reg_rd, mb_out_valid, state_valid, unsup;
  logic [3:0]  cmd_dword, reg_addr;
  logic [31:0] cmd_data, reg_wdata, reg_rdata, flags, hdr, sent, rd;
  apsf_mb_in_t  mb_in, m;
  apsf_mb_out_t mb_out, em;
  apsf_state_fields_t pic_state;
  apsf_mb_out_t exp_q[$];
  int err_total, tests_run, seed, i, k;

  apsf_picture_state u_dut (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_dword(cmd_dword), .cmd_data(cmd_data), .mb_valid(mb_valid), .mb_in(mb_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mb_out_valid(mb_out_valid), .mb_out(mb_out),
    .pic_state(pic_state), .state_valid(state_valid), .chroma_unsupported(unsup));
  apsf_cmd_model u_cs (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_dword(cmd_dword),
    .cmd_data(cmd_data));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // ==========================================================================
  // reference model
  function automatic apsf_mb_out_t exp_mb(logic [31:0] f, logic [31:0] h, apsf_mb_in_t x);
    apsf_mb_out_t o;
    o.header = h;
    o.sync = f[17] ? (x.mb_kind == MB_INTRA && x.nbr_avail) : f[16];
    o.mv_size = (!f[12] && x.mv_size == MV_SIZE_16) ? MV_SIZE_32 : x.mv_size;
    o.dbk_write = f[8];
    o.dbk_nofilter = f[8] & ~x.dbk_slice_en;
    return o;
  endfunction : exp_mb

  function automatic apsf_state_fields_t exp_st(logic [31:0] f);
    return {f[17], f[16], f[12], f[11:10], f[11:10] == CHROMA_MONO, f[8], f[7], f[6], f[5],
            f[4], f[3], f[2], f[1] & ~f[0] & ~f[2], f[0] & ~f[2]};
  endfunction : exp_st

  // every output must match the oldest pending macroblock
  always @(posedge mclk) if (rst_n && mb_out_valid === 1'b1) begin
    em = exp_q.size() ? exp_q.pop_front() : ~mb_out;
    `CHK("mb_out", em, mb_out)
  end

  // ==========================================================================
  // bus tasks
  task automatic reg_rw(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= ~wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_rw

  task automatic commit(input logic [1:0] cf, input logic via_reg, input logic fix);
    flags = $random(seed);
    hdr = $random(seed);
    flags[11:10] = cf;
    if (via_reg) begin
      reg_rw(1'b1, REG_FLAGS, flags);
      reg_rw(1'b1, REG_HEADER, hdr);
      sent = flags;
    end else u_cs.send(flags, hdr, fix, flags[20], 1'b0, sent);
    @(posedge mclk);
    #1;
    `CHK("state", exp_st(sent), pic_state)
    `CHK("valid", 1'b1, state_valid)
    `CHK("unsup", sent[11], unsup)
  endtask : commit

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // ==========================================================================
  // stimulus
  initial begin
    repeat (10000) @(posedge mclk);
    err_total++;
    results();
  end

  initial begin
    seed = 26;
    rst_n = 1'b0;
    mb_valid = 1'b0;
    mb_in = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    // macroblock before any picture state is dropped
    @(posedge mclk);
    mb_valid <= 1'b1;
    mb_in <= 6'($random(seed));
    @(posedge mclk);
    mb_valid <= 1'b0;
    reg_rw(1'b0, REG_STATUS, 32'h0000_0000);
    `CHK("status0", 32'h0000_0000, rd)
    for (i = 0; i < 48; i++) begin
      commit(i[1:0], i[2], i[3]);
      reg_rw(1'b0, REG_FLAGS, 32'h0000_0000);
      `CHK("flags_rd", sent, rd)
      reg_rw(1'b0, REG_HEADER, 32'h0000_0000);
      `CHK("hdr_rd", hdr, rd)
      reg_rw(1'b0, REG_STATUS, 32'h0000_0000);
      `CHK("status", 32'({sent[11], 2'h1}), rd)
      reg_rw(1'b0, 4'hf, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, rd)
      for (k = 0; k < 12; k++) begin
        @(posedge mclk);
        m = 6'($random(seed));
        m.mv_size = m.mv_size[0] ? MV_SIZE_16 : MV_SIZE_32;
        mb_in <= m;
        mb_valid <= k[0] | i[0];
        if (k[0] | i[0]) exp_q.push_back(exp_mb(sent, hdr, m));
      end
      @(posedge mclk);
      mb_valid <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    // lone header must not disturb the committed fields
    u_cs.send(32'h0003_ffff, 32'h1234_5678, 1'b0, 1'b0, 1'b1, rd);
    @(posedge mclk);
    #1;
    `CHK("hold", exp_st(sent), pic_state)
    reg_rw(1'b0, REG_HEADER, 32'h0000_0000);
    `CHK("lone_hdr", 32'h1234_5678, rd)
    // objects keep the committed header, not the lone one
    @(posedge mclk);
    mb_valid <= 1'b1;
    mb_in <= m;
    exp_q.push_back(exp_mb(sent, hdr, m));
    @(posedge mclk);
    mb_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK("drained", 0, exp_q.size())
    results();
  end
endmodule : testbench
`default_nettype wire
